// >>> tws_eeprom_slave.sv
`timescale 1ns/1ps
module tws_eeprom_slave #(
	parameter int WRITE_CYCLES = tws_pkg::TWS_WRITE_CYC,
	parameter int VARIANT = 2
) (
	// Clock and reset.
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// Two-wire bus.
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	// Straps and protect.
	input wire logic select_strap_0_in,
	input wire logic select_strap_1_in,
	input wire logic select_strap_2_in,
	input wire logic write_protect_in,
	// Array read port.
	output logic [8:0] rd_addr_out,
	input wire logic [7:0] rd_data_in,
	// Array write stream.
	output logic wr_valid_out,
	output logic [8:0] wr_addr_out,
	output logic [7:0] wr_data_out,
	input wire logic wr_ready_in,
	output logic busy_out
);
	import tws_pkg::*;

	// ==========================================================
	// Pin synchronisers and edge detection
	// ==========================================================
	logic [1:0] scl_s_q, sda_s_q;
	logic scl_d1_q, sda_d1_q;
	// Two flops before any logic reads SCL or SDA.
	always_ff @(posedge clock_in) begin
		scl_s_q <= {scl_s_q[0], scl_in};
		sda_s_q <= {sda_s_q[0], sda_in};
		scl_d1_q <= scl_s_q[1];
		sda_d1_q <= sda_s_q[1];
	end
	wire scl_rise = scl_s_q[1] & ~scl_d1_q;
	wire scl_fall = ~scl_s_q[1] & scl_d1_q;
	wire start_ev = scl_s_q[1] & scl_d1_q & sda_d1_q & ~sda_s_q[1];
	wire stop_ev = scl_s_q[1] & scl_d1_q & ~sda_d1_q & sda_s_q[1];

	// ==========================================================
	// Variant geometry
	// ==========================================================
	wire big = (VARIANT == 4);
	wire [8:0] amask = (VARIANT == 1) ? 9'h07F : (big ? 9'h1FF : 9'h0FF);
	wire [8:0] lowmask = big ? 9'h00F : 9'h007;
	wire [4:0] page_max = big ? 5'h10 : 5'h08;

	// ==========================================================
	// Protocol state
	// ==========================================================
	tws_state_e st_q;
	logic [2:0] bit_q;
	logic [7:0] sh_q;
	logic ack_phase_q, rw_q;
	logic [8:0] ctr_q, base_q;
	logic [4:0] cnt_q;
	logic [7:0] page_q [0:15];
	logic wrpend_q;
	logic [31:0] wtimer_q;
	logic [4:0] wr_idx_q;
	logic wp_q;
	logic [1:0] wp_s_q;
	// Set by a start so that the SCL fall closing it is not counted as a bit.
	logic lead_q;
	// Output slot and skid slot of the buffer toward the array.
	logic out_v_q, sk_v_q;
	logic [8:0] sk_a_q;
	logic [7:0] sk_d_q;
	logic push, pop;

	wire [7:0] byte_in = {sh_q[6:0], sda_s_q[1]};
	wire [2:0] straps = {select_strap_2_in, select_strap_1_in, select_strap_0_in};
	// Small variants compare three straps, large variant two.
	// The whole address byte already sits in the shifter when the eighth
	// bit's fall is seen, so the match looks at the shifter, not the pin.
	wire addr_hit = (sh_q[7:4] == TWS_TYPE_CODE) &&
		(big ? (sh_q[3:2] == straps[2:1]) : (sh_q[3:1] == straps));
	wire last_bit = (bit_q == TWS_BIT_LAST);
	// The device stays deaf until the page has left the buffer and the write
	// time has run out; a master that polls too early just sees no ack.
	wire busy = wrpend_q | out_v_q | sk_v_q | (wtimer_q != 0);

	// Write protect sampled at the last data bit; master keeps it still.
	always_ff @(posedge clock_in) begin
		wp_s_q <= {wp_s_q[0], write_protect_in};
		if (sys_rst_in) begin
			wp_q <= 1'b0;
		end else if (st_q == TWS_WDATA && scl_rise && last_bit && !ack_phase_q) begin
			wp_q <= wp_s_q[1];
		end
	end

	// Main bus sequencer.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			st_q <= TWS_IDLE;
			bit_q <= 3'h0;
			sh_q <= 8'h00;
			ack_phase_q <= 1'b0;
			rw_q <= 1'b0;
			ctr_q <= TWS_ADDR_ZERO;
			base_q <= TWS_ADDR_ZERO;
			cnt_q <= TWS_PAGE_ZERO;
			lead_q <= 1'b0;
			sda_oe_out <= 1'b0;
		end else if (busy) begin
			st_q <= TWS_IDLE;
			sda_oe_out <= 1'b0;
		end else if (start_ev) begin
			st_q <= TWS_DEVADDR;
			bit_q <= 3'h0;
			ack_phase_q <= 1'b0;
			cnt_q <= TWS_PAGE_ZERO;
			lead_q <= 1'b1;
			sda_oe_out <= 1'b0;
		end else if (stop_ev) begin
			st_q <= TWS_IDLE;
			sda_oe_out <= 1'b0;
		end else begin
			unique case (st_q)
			TWS_IDLE: begin
				sda_oe_out <= 1'b0;
			end
			TWS_DEVADDR, TWS_WORDADDR, TWS_WDATA: begin
				if (scl_rise && !ack_phase_q) begin
					sh_q <= byte_in;
				end
				// The fall that closes a start is not a data bit; counting it
				// would put the acknowledge one clock early.
				if (scl_fall && lead_q) begin
					lead_q <= 1'b0;
				end else if (scl_fall && ack_phase_q) begin
					// End of ninth clock: release and move on.
					ack_phase_q <= 1'b0;
					bit_q <= 3'h0;
					if (st_q == TWS_DEVADDR && rw_q) begin
						st_q <= TWS_RDATA;
						sda_oe_out <= ~rd_data_in[7];
						sh_q <= rd_data_in;
					end else begin
						sda_oe_out <= 1'b0;
						if (st_q == TWS_DEVADDR) begin
							st_q <= TWS_WORDADDR;
						end else begin
							st_q <= TWS_WDATA;
						end
					end
				end else if (scl_fall && last_bit) begin
					ack_phase_q <= 1'b1;
					if (st_q == TWS_DEVADDR) begin
						if (addr_hit) begin
							sda_oe_out <= 1'b1;
							rw_q <= sh_q[0];
							if (big && !sh_q[0]) begin
								base_q <= {sh_q[1], 8'h00};
							end
						end else begin
							st_q <= TWS_IDLE;
						end
					end else if (st_q == TWS_WORDADDR) begin
						sda_oe_out <= 1'b1;
						ctr_q <= (base_q | {1'b0, sh_q}) & amask;
					end else begin
						sda_oe_out <= 1'b1;
						page_q[ctr_q[3:0] & lowmask[3:0]] <= sh_q;
						ctr_q <= (ctr_q & ~lowmask) | ((ctr_q + TWS_ADDR_ONE) & lowmask);
						if (cnt_q != page_max) begin
							cnt_q <= cnt_q + TWS_PAGE_ONE;
						end
					end
				end else if (scl_fall) begin
					bit_q <= bit_q + 3'h1;
				end
			end
			TWS_RDATA: begin
				if (scl_fall) begin
					if (last_bit) begin
						// Counter steps after the eighth bit.
						ctr_q <= (ctr_q + TWS_ADDR_ONE) & amask;
						sda_oe_out <= 1'b0;
						st_q <= TWS_RACK;
					end else begin
						bit_q <= bit_q + 3'h1;
						sh_q <= {sh_q[6:0], 1'b0};
						sda_oe_out <= ~sh_q[6];
					end
				end
			end
			TWS_RACK: begin
				if (scl_rise) begin
					ack_phase_q <= ~sda_s_q[1];
				end
				if (scl_fall) begin
					bit_q <= 3'h0;
					if (ack_phase_q) begin
						st_q <= TWS_RDATA;
						sh_q <= rd_data_in;
						sda_oe_out <= ~rd_data_in[7];
					end else begin
						st_q <= TWS_IDLE;
					end
					ack_phase_q <= 1'b0;
				end
			end
			default: st_q <= TWS_IDLE;
			endcase
		end
	end
	assign sda_out = 1'b0;
	assign rd_addr_out = ctr_q;

	// ==========================================================
	// Page hand-over toward the array
	// ==========================================================
	// Start of page is the counter minus received count, within low bits.
	// A page that wrapped starts just past the newest byte, so each slot is
	// written once, with the data that overwrote it last.
	wire [8:0] pstart = (ctr_q & ~lowmask) | ((ctr_q - {4'h0, cnt_q}) & lowmask);
	wire [8:0] waddr = (pstart & ~lowmask) | ((pstart + {4'h0, wr_idx_q}) & lowmask);
	// The page side offers a word whenever the skid slot is empty, so it never
	// has to look at the array's ready; the array takes the output slot.
	assign push = wrpend_q && !sk_v_q;
	assign pop = out_v_q && wr_ready_in;

	// A stop after at least one data byte hands the page over unless wp_q is set; the index walks
	// the received bytes in address order, one step per word pushed.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			wrpend_q <= 1'b0;
			wr_idx_q <= TWS_PAGE_ZERO;
		end else if (stop_ev && !busy && st_q == TWS_WDATA && cnt_q != TWS_PAGE_ZERO) begin
			wrpend_q <= ~wp_q;
			wr_idx_q <= TWS_PAGE_ZERO;
		end else if (push) begin
			wr_idx_q <= wr_idx_q + TWS_PAGE_ONE;
			if (wr_idx_q + TWS_PAGE_ONE == cnt_q) begin
				wrpend_q <= 1'b0;
			end
		end
	end

	// Two-entry buffer: the output slot faces the array and the skid slot
	// catches the word already offered when the array stalls. The skid slot
	// is always drained first, so words leave in the order they came in.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			out_v_q <= 1'b0;
			sk_v_q <= 1'b0;
			sk_a_q <= TWS_ADDR_ZERO;
			sk_d_q <= 8'h00;
			wr_addr_out <= TWS_ADDR_ZERO;
			wr_data_out <= 8'h00;
		end else if (!out_v_q || wr_ready_in) begin
			// Output slot is free or being taken: refill it, older word first.
			if (sk_v_q) begin
				wr_addr_out <= sk_a_q;
				wr_data_out <= sk_d_q;
				sk_v_q <= 1'b0;
				out_v_q <= 1'b1;
			end else begin
				wr_addr_out <= waddr;
				wr_data_out <= page_q[waddr[3:0] & lowmask[3:0]];
				out_v_q <= push;
			end
		end else if (push) begin
			// Output slot is stalled: park the offered word beside it.
			sk_a_q <= waddr;
			sk_d_q <= page_q[waddr[3:0] & lowmask[3:0]];
			sk_v_q <= 1'b1;
		end
	end
	assign wr_valid_out = out_v_q;

	// ==========================================================
	// Write cycle timer
	// ==========================================================
	// The write time starts when the last word leaves the buffer: nothing
	// is left behind it and nothing is still waiting to be pushed.
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			wtimer_q <= 32'h0;
		end else if (pop && !sk_v_q && !wrpend_q) begin
			wtimer_q <= 32'(WRITE_CYCLES);
		end else if (wtimer_q != 0) begin
			wtimer_q <= wtimer_q - 32'h1;
		end
	end
	assign busy_out = busy;
endmodule

// >>> tws_pkg.sv
// Operation
// - Eight-bit bytes, ninth clock acknowledges.
// - No acknowledge during internal write cycle.
// - Address byte: fixed four-bit type code.
// - Small variants match three select straps.
// - Large variant: two straps, block select bit.
// - Byte write: address, word, data, stop.
// - Page holds 8 or 16 bytes.
// - Stop writes only bytes received.
// - Small variants wrap low three bits.
// - Large variant wraps low four bits.
// - Write protect high blocks array writes.
// - Write cycle ignores bus; master polls.
// - Counter holds last address plus one.
// - Read bit one sends byte at counter.
// - Read counter increments after eighth bit.
// - Dummy write loads counter for random read.
// - Master acknowledge continues sequential read.
// - Read counter wraps last to first.
// - Write increment keeps upper bits fixed.
// - Start and stop change SDA while SCL high.
// - Stop during read returns to standby.
// - Stop during write data starts write.
package tws_pkg;
	// Device type code; value is arbitrary for this model.
	localparam logic [3:0] TWS_TYPE_CODE = 4'h5;
	localparam int TWS_WRITE_MS = 10;
	localparam int TWS_CLK_KHZ = 125000;
	localparam int TWS_WRITE_CYC = TWS_WRITE_MS * TWS_CLK_KHZ;
	localparam logic [2:0] TWS_BIT_LAST = 3'h7;
	localparam logic [8:0] TWS_ADDR_ZERO = 9'h000;
	localparam logic [8:0] TWS_ADDR_ONE = 9'h001;
	localparam logic [4:0] TWS_PAGE_ZERO = 5'h00;
	localparam logic [4:0] TWS_PAGE_ONE = 5'h01;
	typedef enum logic [2:0] {
		TWS_IDLE = 3'b000,
		TWS_DEVADDR = 3'b001,
		TWS_WORDADDR = 3'b010,
		TWS_WDATA = 3'b011,
		TWS_RDATA = 3'b100,
		TWS_RACK = 3'b101
	} tws_state_e;
endpackage

// >>> tws_eeprom_slave_checker.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the two-wire slave.
module tws_chk (
	// Watched ports.
	input wire logic clock_in,
	input wire logic sys_rst_in,
	input wire logic scl_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic [8:0] rd_addr_out,
	input wire logic wr_valid_out,
	input wire logic [8:0] wr_addr_out,
	input wire logic wr_ready_in,
	input wire logic busy_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);
	// The line is only ever pulled low, and never while a write cycle runs.
	busy_quiet_a: assert property (busy_out |-> !sda_oe_out) else $error("ack while busy");
	drive_low_a: assert property (sda_oe_out |-> !sda_out) else $error("sda driven high");
	oe_move_a: assert property ($changed(sda_oe_out) |-> !scl_in) else $error("sda moved");
	oe_hold_a: assert property ($rose(sda_oe_out) |=> sda_oe_out [*8]) else $error("ack short");
	wr_busy_a: assert property (wr_valid_out |-> busy_out) else $error("write not busy");
	// A stalled word must stay valid with its address unchanged, so a slow array loses nothing.
	wr_hold_a: assert property (wr_valid_out && !wr_ready_in |=> wr_valid_out
		&& $stable(wr_addr_out)) else $error("stalled word lost");
	page_fix_a: assert property (wr_valid_out && $past(wr_valid_out) |->
		wr_addr_out[8:3] == $past(wr_addr_out[8:3])) else $error("page moved");
	cnt_move_a: assert property ($changed(rd_addr_out) |-> !scl_in) else $error("count moved");
endmodule

// >>> tws_bm.sv
`timescale 1ns/1ps
// ==========================================================
// Behavioural bus master; SCL stands high between frames.
module tws_bm (
	// Clock.
	input wire logic clk_in,
	// Device pins.
	input wire logic dev_oe_in,
	input wire logic dev_out_in,
	output logic scl_out,
	output logic sda_out
);
	logic sda_q = 1'b1;
	// Open-drain wire with a pull-up: low when either party pulls it.
	assign sda_out = sda_q & ~(dev_oe_in & ~dev_out_in);
	initial scl_out = 1'b1;
	// One bit of 160 ns; data moves only while SCL is low.
	task automatic bx(input logic b, output logic r);
		repeat (3) @(posedge clk_in);
		sda_q <= b;
		repeat (7) @(posedge clk_in);
		scl_out <= 1'b1;
		repeat (10) @(posedge clk_in);
		r = sda_out;
		scl_out <= 1'b0;
	endtask
	// Start is cond(1,0), stop is cond(0,1): SDA moves while SCL is high.
	task automatic cond(input logic a, input logic b);
		repeat (3) @(posedge clk_in);
		sda_q <= a;
		repeat (7) @(posedge clk_in);
		scl_out <= 1'b1;
		repeat (10) @(posedge clk_in);
		sda_q <= b;
		repeat (10) @(posedge clk_in);
		if (!b) scl_out <= 1'b0;
	endtask
	// Sends a byte MSB first; ack is true when the ninth bit came back low.
	task automatic wb(input logic [7:0] v, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bx(v[i], r);
		bx(1'b1, r);
		ack = ~r;
	endtask
	// Receives a byte; the last one gets no ack so the device lets go.
	task automatic rb(input logic last, output logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) bx(1'b1, v[i]);
		bx(last, r);
	endtask
endmodule

// >>> tws_eeprom_slave_tb.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the two-wire slave.
module tws_eeprom_slave_tb;
	import tws_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wp = 1'b0;
	logic rdy = 1'b0;
	logic [2:0] strap = 3'h5;
	logic scl, sda, oe, dout, wv, busy, a;
	logic [8:0] ra, wa;
	logic [7:0] wd, v;
	logic [7:0] mem [512];
	logic [7:0] em [256];
	logic [6:0] dev;
	int err_total = 0;
	int tests_run = 0;
	logic [23:0] rows [3] = '{24'h00A5A5, 24'h7F3C3C, 24'hFF0000};
	assign dev = {TWS_TYPE_CODE, strap};
	always #4 clk = ~clk;
	// Array sink; ready toggles every cycle so the buffer keeps meeting stalls.
	always @(posedge clk) begin
		rdy <= ~rdy;
		if (wv && rdy) mem[wa] <= wd;
	end
	tws_eeprom_slave #(.WRITE_CYCLES(400), .VARIANT(2)) i_tws_eeprom_slave (.clock_in(clk),
		.sys_rst_in(rst), .scl_in(scl), .sda_in(sda), .sda_out(dout), .sda_oe_out(oe),
		.select_strap_0_in(strap[0]), .select_strap_1_in(strap[1]), .select_strap_2_in(strap[2]),
		.write_protect_in(wp), .rd_addr_out(ra), .rd_data_in(mem[ra]), .wr_valid_out(wv),
		.wr_addr_out(wa), .wr_data_out(wd), .wr_ready_in(rdy), .busy_out(busy));
	tws_bm i_tws_bm (.clk_in(clk), .dev_oe_in(oe), .dev_out_in(dout), .scl_out(scl), .sda_out(sda));
	task automatic ck(input string nm, input logic [7:0] e, input logic [7:0] s);
		tests_run++;
		if (s !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask
	// Page write of n bytes; the model follows the low-bit wrap and the protect pin.
	task automatic put(input logic [7:0] w, input int n, input logic [7:0] d);
		i_tws_bm.cond(1'b1, 1'b0);
		i_tws_bm.wb({dev, 1'b0}, a);
		ck("wr addr ack", 8'h01, {7'h0, a});
		i_tws_bm.wb(w, a);
		for (int i = 0; i < n; i++) begin
			i_tws_bm.wb(d + i[7:0], a);
			ck("data ack", 8'h01, {7'h0, a});
			if (!wp) em[{w[7:3], w[2:0] + i[2:0]}] = d + i[7:0];
		end
		i_tws_bm.cond(1'b0, 1'b1);
		i_tws_bm.cond(1'b1, 1'b0);
		i_tws_bm.wb({dev, 1'b1}, a);
		if (!wp) ck("busy ack", 8'h00, {7'h0, a});
		i_tws_bm.cond(1'b0, 1'b1);
		for (int k = 0; k < 3000 && busy === 1'b1; k++) @(posedge clk);
		ck("busy end", 8'h00, {7'h0, busy});
	endtask
	// Current address read of n bytes, each compared with the model.
	task automatic cur(input logic [7:0] w, input int n);
		i_tws_bm.cond(1'b1, 1'b0);
		i_tws_bm.wb({dev, 1'b1}, a);
		ck("rd addr ack", 8'h01, {7'h0, a});
		for (int i = 0; i < n; i++) begin
			i_tws_bm.rb(i == n - 1, v);
			ck("rd data", em[w + i[7:0]], v);
		end
		i_tws_bm.cond(1'b0, 1'b1);
	endtask
	// Dummy write to load the counter, then a read from there.
	task automatic get(input logic [7:0] w, input int n);
		i_tws_bm.cond(1'b1, 1'b0);
		i_tws_bm.wb({dev, 1'b0}, a);
		i_tws_bm.wb(w, a);
		ck("word ack", 8'h01, {7'h0, a});
		cur(w, n);
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Main sequence: table rows first, then the awkward cases.
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		foreach (em[i]) em[i] = 8'hFF;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		ck("reset outs", 8'h00, {5'h0, oe, wv, busy});
		foreach (rows[r]) begin
			put(rows[r][23:16], 1, rows[r][15:8]);
			get(rows[r][23:16], 1);
			ck("row data", rows[r][7:0], v);
		end
		put(8'h1D, 9, 8'h40);
		get(8'h18, 8);
		get(8'hFE, 3);
		cur(8'h01, 1);
		wp <= 1'b1;
		put(8'h40, 1, 8'h77);
		wp <= 1'b0;
		get(8'h40, 1);
		// Foreign straps and a foreign type code must go unanswered.
		for (int b = 0; b < 4; b++) begin
			i_tws_bm.cond(1'b1, 1'b0);
			i_tws_bm.wb({dev ^ (7'h01 << b), 1'b1}, a);
			ck("foreign ack", 8'h00, {7'h0, a});
			i_tws_bm.cond(1'b0, 1'b1);
		end
		close_out();
	end
	// Watchdog well beyond the expected run length.
	initial begin
		repeat (40000) @(posedge clk);
		err_total++;
		close_out();
	end
endmodule
bind tws_eeprom_slave tws_chk i_tws_chk (.*);
